// ==== hdl/wiper_pkg.sv ====
// Constants and types for the two-wire wiper slave.
// Assumes a single 100 MHz clock domain inside the device.
package wiper_pkg;

  localparam logic [6:0] ADDR_MAIN     = 7'h2e;
  localparam logic [6:0] ADDR_ALT      = 7'h3e;
  localparam logic [6:0] GEN_CALL      = 7'h00;
  localparam logic [6:0] WIPER_DEFAULT = 7'h3f;
  localparam logic [7:0] CMD_WIPER     = 8'h00;
  localparam logic [7:0] FILL_BYTE     = 8'hff;
  localparam logic [3:0] FIRST_BIT     = 4'h0;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  localparam logic [3:0] ACK_BIT       = 4'h8;
  localparam logic [2:0] SYNC_IDLE     = 3'h7;

  typedef enum logic [5:0] {
    st_idle   = 6'h01,
    st_addr   = 6'h02,
    st_cmd    = 6'h04,
    st_wdata  = 6'h08,
    st_rdata  = 6'h10,
    st_ignore = 6'h20
  } state_t;

endpackage

// ==== hdl/line_if.sv ====
// Filtered bus levels and bus events passed from the sampler to the slave.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport src (output scl, output sda, output scl_rise, output scl_fall, output start,
               output stop);
  modport dst (input scl, input sda, input scl_rise, input scl_fall, input start,
               input stop);
endinterface
`default_nettype wire

// ==== hdl/line_sampler.sv ====
// Pin synchroniser, glitch filter and start/stop/edge detector.
// Assumes clk is much faster than the bus clock.
`timescale 1ns/1ps
`default_nettype none
module line_sampler (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic scl_i,
  input  wire logic sda_i,
  line_if.src       ln
);
  logic [2:0] scl_s_q, scl_s_d;
  logic [2:0] sda_s_q, sda_s_d;
  logic       scl_q, scl_d;
  logic       sda_q, sda_d;
  logic       rise_q, rise_d;
  logic       fall_q, fall_d;
  logic       start_q, start_d;
  logic       stop_q, stop_d;

  // Level moves only when second and third stage agree: spike filter
  always_comb
  begin
    scl_s_d = {scl_s_q[1:0], scl_i};
    sda_s_d = {sda_s_q[1:0], sda_i};
    scl_d   = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
    sda_d   = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
    rise_d  = scl_d & ~scl_q;
    fall_d  = ~scl_d & scl_q;
    start_d = scl_q & scl_d & sda_q & ~sda_d;
    stop_d  = scl_q & scl_d & ~sda_q & sda_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      scl_s_q <= wiper_pkg::SYNC_IDLE;
      sda_s_q <= wiper_pkg::SYNC_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end
    else
    begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      scl_q   <= scl_d;
      sda_q   <= sda_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
      start_q <= start_d;
      stop_q  <= stop_d;
    end
  end

  assign ln.scl      = scl_q;
  assign ln.sda      = sda_q;
  assign ln.scl_rise = rise_q;
  assign ln.scl_fall = fall_q;
  assign ln.start    = start_q;
  assign ln.stop     = stop_q;
endmodule // line_sampler
`default_nettype wire

// ==== hdl/wiper_reg.sv ====
// Seven-bit volatile wiper register with power-on mid-scale value.
// Assumes rstn is the power-on reset, never the bus recovery sequence.
`timescale 1ns/1ps
`default_nettype none
module wiper_reg (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [6:0] wiper
);
  logic [6:0] wiper_q, wiper_d;

  always_comb
  begin
    wiper_d = wiper_q;
    if (we)
      wiper_d = wdata[6:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      wiper_q <= wiper_pkg::WIPER_DEFAULT;
    else
      wiper_q <= wiper_d;
  end

  assign wiper = wiper_q;
endmodule // wiper_reg
`default_nettype wire

// ==== hdl/wiper_i2c_slave.sv ====
// Two-wire slave front end of a volatile digital potentiometer.
// Assumes an external master clocks the bus at up to 400 kb/s.
`timescale 1ns/1ps
`default_nettype none
module wiper_i2c_slave #(
  parameter bit ALT_ADDR = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  output logic            scl_o,
  output logic            scl_oe_n,
  output logic      [6:0] wiper
);
  // Fixed at build time, no pins select it
  localparam logic [6:0] OWN_ADDR = ALT_ADDR ? wiper_pkg::ADDR_ALT
                                             : wiper_pkg::ADDR_MAIN;

  line_if ln ();

  wiper_pkg::state_t state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] cmd_q, cmd_d;
  logic       cmd_seen_q, cmd_seen_d;
  logic       rw_q, rw_d;
  logic       mack_q, mack_d;
  logic       rel_q, rel_d;
  logic       seen_rise_q, seen_rise_d;
  logic       we;

  function automatic logic addr_ok(input logic [7:0] b);
    addr_ok = (b[7:1] == OWN_ADDR) && (b[7:1] != wiper_pkg::GEN_CALL);
  endfunction

  function automatic logic [7:0] rd_byte(input logic [7:0] c, input logic [6:0] w);
    rd_byte = (c == wiper_pkg::CMD_WIPER) ? {1'b0, w} : wiper_pkg::FILL_BYTE;
  endfunction

  // Filter latency is a few clocks, far inside a 400 kb/s bit
  line_sampler u_sampler (
    .clk   (clk),
    .rstn  (rstn),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ln    (ln)
  );

  wiper_reg u_wiper (
    .clk   (clk),
    .rstn  (rstn),
    .we    (we),
    .wdata (rx_q),
    .wiper (wiper)
  );

  always_comb
  begin
    state_d    = state_q;
    bit_d      = bit_q;
    rx_d       = rx_q;
    tx_d       = tx_q;
    cmd_d      = cmd_q;
    cmd_seen_d = cmd_seen_q;
    rw_d       = rw_q;
    mack_d     = mack_q;
    rel_d      = rel_q;
    seen_rise_d = seen_rise_q;
    we         = 1'b0;
    if (ln.stop)
    begin
      state_d    = wiper_pkg::st_idle;
      rel_d      = 1'b1;
      cmd_seen_d = 1'b0;
    end
    else if (ln.start)
    begin
      // Command code survives so a repeated start can read it back
      state_d = wiper_pkg::st_addr;
      bit_d   = wiper_pkg::FIRST_BIT;
      seen_rise_d = 1'b0; // Clock fall that closes a start is not a bit
      rel_d   = 1'b1;
    end
    else if (state_q != wiper_pkg::st_idle && state_q != wiper_pkg::st_ignore)
    begin
      if (ln.scl_rise)
      begin
        seen_rise_d = 1'b1;
        if (bit_q != wiper_pkg::ACK_BIT)
          rx_d = {rx_q[6:0], ln.sda};
        if (state_q == wiper_pkg::st_rdata)
        begin
          if (bit_q == wiper_pkg::ACK_BIT)
            mack_d = ~ln.sda;
          else if (tx_q[7] && !ln.sda)
          begin
            // Someone else holds data low while we released it
            state_d = wiper_pkg::st_ignore;
            rel_d   = 1'b1;
          end
        end
      end
      else if (ln.scl_fall && seen_rise_q)
      begin
        // Drive changes happen just after clock falls, apart from releases on start, stop or collision
        seen_rise_d = 1'b0;
        if (bit_q == wiper_pkg::LAST_BIT)
        begin
          bit_d = wiper_pkg::ACK_BIT;
          case (state_q)
            wiper_pkg::st_addr:
            begin
              // A read with no command code is undefined
              if (addr_ok(rx_q) && (!rx_q[0] || cmd_seen_q))
              begin
                rel_d = 1'b0;
                rw_d  = rx_q[0];
              end
              else
              begin
                rel_d   = 1'b1;
                state_d = wiper_pkg::st_ignore;
              end
            end
            wiper_pkg::st_cmd:
            begin
              rel_d      = 1'b0;
              cmd_d      = rx_q;
              cmd_seen_d = 1'b1;
            end
            wiper_pkg::st_wdata:
            begin
              rel_d = 1'b0;
              we    = (cmd_q == wiper_pkg::CMD_WIPER);
            end
            default:
              rel_d = 1'b1;
          endcase
        end
        else if (bit_q == wiper_pkg::ACK_BIT)
        begin
          bit_d = wiper_pkg::FIRST_BIT;
          rel_d = 1'b1;
          case (state_q)
            wiper_pkg::st_addr:
            begin
              if (rw_q)
              begin
                state_d = wiper_pkg::st_rdata;
                tx_d    = rd_byte(cmd_q, wiper);
                rel_d   = tx_d[7];
              end
              else
              begin
                state_d    = wiper_pkg::st_cmd;
                cmd_seen_d = 1'b0;
              end
            end
            wiper_pkg::st_cmd:
              state_d = wiper_pkg::st_wdata;
            wiper_pkg::st_rdata:
            begin
              if (mack_q)
              begin
                tx_d  = rd_byte(cmd_q, wiper);
                rel_d = tx_d[7];
              end
              else
                state_d = wiper_pkg::st_ignore;
            end
            default:
              state_d = state_q;
          endcase
        end
        else
        begin
          bit_d = bit_q + 4'h1;
          if (state_q == wiper_pkg::st_rdata)
          begin
            tx_d  = {tx_q[6:0], 1'b1};
            rel_d = tx_d[7];
          end
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q    <= wiper_pkg::st_idle;
      bit_q      <= wiper_pkg::FIRST_BIT;
      rx_q       <= wiper_pkg::FILL_BYTE;
      tx_q       <= wiper_pkg::FILL_BYTE;
      cmd_q      <= wiper_pkg::CMD_WIPER;
      cmd_seen_q <= 1'b0;
      rw_q       <= 1'b0;
      mack_q     <= 1'b0;
      rel_q      <= 1'b1;
      seen_rise_q <= 1'b0;
      sda_o      <= 1'b0;
      scl_o      <= 1'b0;
      scl_oe_n   <= 1'b1;
    end
    else
    begin
      state_q    <= state_d;
      bit_q      <= bit_d;
      rx_q       <= rx_d;
      tx_q       <= tx_d;
      cmd_q      <= cmd_d;
      cmd_seen_q <= cmd_seen_d;
      rw_q       <= rw_d;
      mack_q     <= mack_d;
      rel_q      <= rel_d;
      seen_rise_q <= seen_rise_d;
      sda_o      <= 1'b0;
      scl_o      <= 1'b0;
      scl_oe_n   <= 1'b1;
    end
  end

  assign sda_oe_n = rel_q;

  sequence s_last_fall(wiper_pkg::state_t st);
    ln.scl_fall && !ln.start && !ln.stop && state_q == st && bit_q == wiper_pkg::LAST_BIT;
  endsequence

  sequence s_ack_fall(wiper_pkg::state_t st);
    ln.scl_fall && !ln.start && !ln.stop && state_q == st && bit_q == wiper_pkg::ACK_BIT;
  endsequence

  property p_start_resets;
    @(posedge clk) disable iff (!rstn)
    ln.start && !ln.stop |=> state_q == wiper_pkg::st_addr && rel_q
      && bit_q == wiper_pkg::FIRST_BIT && !seen_rise_q;
  endproperty
  a_start_resets: assert property (p_start_resets) else $error("start did not reset");

  property p_stop_idle;
    @(posedge clk) disable iff (!rstn)
    ln.stop |=> state_q == wiper_pkg::st_idle && rel_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

  property p_sda_change_low;
    @(posedge clk) disable iff (!rstn)
    $changed(rel_q) |-> !ln.scl;
  endproperty
  a_sda_change_low: assert property (p_sda_change_low) else $error("sda moved, scl high");

  property p_ack_own;
    @(posedge clk) disable iff (!rstn)
    s_last_fall(wiper_pkg::st_addr) ##0 (addr_ok(rx_q) && !rx_q[0])
      |=> !rel_q [*2];
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("own address not acked");

  property p_nack_other;
    @(posedge clk) disable iff (!rstn)
    s_last_fall(wiper_pkg::st_addr) ##0 !addr_ok(rx_q)
      |=> rel_q && state_q == wiper_pkg::st_ignore;
  endproperty
  a_nack_other: assert property (p_nack_other) else $error("foreign address acked");

  property p_gen_call;
    @(posedge clk) disable iff (!rstn)
    s_last_fall(wiper_pkg::st_addr) ##0 (rx_q[7:1] == wiper_pkg::GEN_CALL) |=> rel_q;
  endproperty
  a_gen_call: assert property (p_gen_call) else $error("general call acked");

  property p_wiper_write;
    @(posedge clk) disable iff (!rstn)
    $changed(wiper) |-> $past(state_q) == wiper_pkg::st_wdata
      && $past(bit_q) == wiper_pkg::LAST_BIT && $past(ln.scl_fall) && wiper == $past(rx_q[6:0]);
  endproperty
  a_wiper_write: assert property (p_wiper_write) else $error("wiper moved off ack");

  property p_master_nack;
    @(posedge clk) disable iff (!rstn)
    s_ack_fall(wiper_pkg::st_rdata) ##0 !mack_q
      |=> state_q == wiper_pkg::st_ignore && rel_q;
  endproperty
  a_master_nack: assert property (p_master_nack) else $error("nack did not abort");

  property p_ignore_hold;
    @(posedge clk) disable iff (!rstn)
    state_q == wiper_pkg::st_ignore && !ln.start && !ln.stop
      |=> state_q == wiper_pkg::st_ignore && rel_q;
  endproperty
  a_ignore_hold: assert property (p_ignore_hold) else $error("ignore state left");

  property p_por_default;
    @(posedge clk) !rstn |=> wiper == wiper_pkg::WIPER_DEFAULT;
  endproperty
  a_por_default: assert property (p_por_default) else $error("wiper not mid-scale");

  property p_no_clock_drive;
    @(posedge clk) disable iff (!rstn)
    scl_oe_n;
  endproperty
  a_no_clock_drive: assert property (p_no_clock_drive) else $error("scl driven");
endmodule // wiper_i2c_slave
`default_nettype wire

// ==== verif/bus_master_model.sv ====
// Behavioural two-wire bus master making clock and data, open-drain style.
// Assumes the bench resolves wire levels with pull-ups; 1 here means released.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input  wire logic clk,
  input  wire logic sda_in,
  output var  logic scl_drv,
  output var  logic sda_drv
);
  int half = 20;  // Cycles per clock phase; 125 gives 400 kb/s

  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // From idle or low clock, so it serves as repeated start too
  task automatic start();
    tick(1);  // Callers may sit on a falling edge
    sda_drv <= 1'b1;
    tick(half / 2);
    scl_drv <= 1'b1;
    tick(half / 2);
    sda_drv <= 1'b0;
    tick(half / 2);
    scl_drv <= 1'b0;
    tick(half / 2);
  endtask

  task automatic stop();
    tick(1);
    sda_drv <= 1'b0;
    tick(half / 2);
    scl_drv <= 1'b1;
    tick(half / 2);
    sda_drv <= 1'b1;
    tick(half);
  endtask

  // Data moves mid-low only; sampled just before the fall
  task automatic xbit(input logic b, output logic r);
    sda_drv <= b;
    tick(half / 2);
    scl_drv <= 1'b1;
    tick(half);
    r = sda_in;
    scl_drv <= 1'b0;
    tick(half / 2);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(~ack, r);
  endtask

  // Nine released bits force a not-acknowledge out of a stuck slave
  task automatic recover();
    logic r;
    start();
    repeat (9) xbit(1'b1, r);
    start();
    stop();
  endtask
endmodule  // bus_master_model
`default_nettype wire

// ==== verif/i2c_slave_wiper_interface_tb.sv ====
// Self-checking bench for the two-wire wiper slave.
// Assumes the master model above; wires resolved here with pull-ups.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module i2c_slave_wiper_interface_tb;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       scl_m;
  logic       sda_m;
  logic       sda_o;
  logic       sda_oe_n;
  logic       scl_o;
  logic       scl_oe_n;
  logic [6:0] wiper;
  logic [6:0] w_exp;
  wire        scl_w;
  wire        sda_w;
  int         err_count = 0;
  int         tests_run = 0;

  // Open-drain wires; nobody pulling means high
  assign scl_w = scl_m & (scl_oe_n | scl_o);
  assign sda_w = sda_m & (sda_oe_n | sda_o);

  always #5 clk = ~clk;

  wiper_i2c_slave #(.ALT_ADDR(1'b0)) u_dut (
    .clk(clk), .rstn(rstn), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .wiper(wiper));

  bus_master_model u_mst (.clk(clk), .sda_in(sda_w), .scl_drv(scl_m), .sda_drv(sda_m));

  always @(negedge clk) if (rstn) `CHK({scl_oe_n, scl_o, sda_o}, 3'h4)

  function automatic logic [7:0] exp_rd(input logic [7:0] cm, input logic [6:0] w);
    return (cm == wiper_pkg::CMD_WIPER) ? {1'b0, w} : wiper_pkg::FILL_BYTE;
  endfunction

  task automatic wr(input logic [6:0] ad, input logic [7:0] cm, input logic [7:0] dt,
                    output logic [2:0] ak);
    u_mst.start();
    u_mst.wbyte({ad, 1'b0}, ak[2]);
    u_mst.wbyte(cm, ak[1]);
    u_mst.wbyte(dt, ak[0]);
    u_mst.stop();
    @(negedge clk);
  endtask

  // Two bytes read: first acked by master, second refused
  task automatic rd(input logic [7:0] cm, output logic [7:0] r, output logic [2:0] ak);
    logic [7:0] r2;
    u_mst.start();
    u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b0}, ak[2]);
    u_mst.wbyte(cm, ak[1]);
    u_mst.start();
    u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b1}, ak[0]);
    u_mst.rbyte(1'b1, r);
    u_mst.rbyte(1'b0, r2);
    @(negedge clk);
    `CHK(sda_oe_n, 1'b1)
    `CHK(r2, r)
    u_mst.stop();
    @(negedge clk);
  endtask

  task automatic wr_rd(input logic [7:0] cm, input logic [7:0] d);
    logic [2:0] a;
    logic [7:0] r;
    wr(wiper_pkg::ADDR_MAIN, cm, d, a);
    `CHK(a, 3'h7)
    if (cm == wiper_pkg::CMD_WIPER) w_exp = d[6:0];
    `CHK(wiper, w_exp)
    rd(cm, r, a);
    `CHK(a, 3'h7)
    `CHK(r, exp_rd(cm, w_exp))
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] r;
    logic [2:0] a;
    logic [6:0] bad [3];
    void'($urandom(91));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK(wiper, wiper_pkg::WIPER_DEFAULT)
    `CHK(sda_oe_n, 1'b1)
    w_exp = wiper_pkg::WIPER_DEFAULT;
    // Corners first, then random; one pass at 400 kb/s
    for (int i = 0; i < 6; i++)
    begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : 8'($urandom);
      u_mst.half = (i == 2) ? 125 : 20;
      wr_rd(wiper_pkg::CMD_WIPER, d);
    end
    wr_rd(8'($urandom % 255 + 1), 8'($urandom));
    // Foreign, general call and near-miss addresses
    bad[0] = wiper_pkg::ADDR_ALT;
    bad[1] = wiper_pkg::GEN_CALL;
    bad[2] = wiper_pkg::ADDR_MAIN ^ (7'h01 << ($urandom % 7));
    for (int i = 0; i < 3; i++)
    begin
      wr(bad[i], wiper_pkg::CMD_WIPER, 8'($urandom), a);
      `CHK(a, 3'h0)
      `CHK(wiper, w_exp)
    end
    // Byte cut by stop, then by a stray start
    for (int k = 0; k < 2; k++)
    begin
      d = ~{1'b0, w_exp};
      u_mst.start();
      u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b0}, a[2]);
      u_mst.wbyte(wiper_pkg::CMD_WIPER, a[1]);
      for (int i = 7; i >= 4; i--) u_mst.xbit(d[i], r[0]);
      if (k == 1) u_mst.start();
      u_mst.stop();
      @(negedge clk);
      `CHK(wiper, w_exp)
    end
    // Read control byte with no command code is undefined
    u_mst.start();
    u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b1}, a[2]);
    u_mst.wbyte(wiper_pkg::CMD_WIPER, a[1]);
    u_mst.wbyte(8'h15, a[0]);
    u_mst.stop();
    @(negedge clk);
    `CHK(a, 3'h0)
    `CHK(wiper, w_exp)
    // Back-to-back data bytes, last one wins
    d = 8'($urandom);
    u_mst.start();
    u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b0}, a[2]);
    u_mst.wbyte(wiper_pkg::CMD_WIPER, a[1]);
    u_mst.wbyte(~d, a[0]);
    u_mst.wbyte(d, a[0]);
    u_mst.stop();
    @(negedge clk);
    w_exp = d[6:0];
    `CHK(wiper, w_exp)
    // Master forces a zero over a transmitted one; slave must back off
    wr(wiper_pkg::ADDR_MAIN, wiper_pkg::CMD_WIPER, 8'hc0, a);
    w_exp = 7'h40;
    u_mst.start();
    u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b0}, a[2]);
    u_mst.wbyte(wiper_pkg::CMD_WIPER, a[1]);
    u_mst.start();
    u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b1}, a[0]);
    for (int i = 7; i >= 0; i--) u_mst.xbit(i != 6, r[i]);
    u_mst.stop();
    @(negedge clk);
    `CHK(r, 8'h3f)
    `CHK(a, 3'h7)
    `CHK(wiper, w_exp)
    // Slave left driving a zero, freed by the recovery sequence
    u_mst.start();
    u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b0}, a[2]);
    u_mst.wbyte(wiper_pkg::CMD_WIPER, a[1]);
    u_mst.start();
    u_mst.wbyte({wiper_pkg::ADDR_MAIN, 1'b1}, a[0]);
    u_mst.recover();
    @(negedge clk);
    `CHK(sda_oe_n, 1'b1)
    `CHK(wiper, w_exp)
    wr_rd(wiper_pkg::CMD_WIPER, 8'($urandom));
    tally_and_finish();
  end
endmodule  // i2c_slave_wiper_interface_tb
`default_nettype wire
